// ### inc/die_temp_pkg.sv
// constants shared by the die temperature readout device end and core end
// Behaviour
// (R1) core raises access enable to start reading
// (R2) active-high reset clears sensor registers anytime; the access enable edge detector register is set high instead
// (R3) one conversion lasts 1024 converter clocks
// (R4) conversion done pulse is one cycle
// (R5) core latches code on done falling edge
// (R6) result is 10-bit unsigned code
// (R7) throughput near one thousand samples per second
// (R8) degrees equal code times 693/1024 minus 265
// (R9) conversions repeat while enabled and not reset
// (R10) code holds stable across the done pulse
package die_temp_pkg;

  // ==========================================================
  // code format
  localparam int CODE_W = 10;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int CLK_HZ = CLK_MHZ * 1000000;
  localparam int SAMPLE_HZ = 1000;
  localparam int CONV_CYCLES = 1024;
  localparam int CONV_CNT_W = $clog2(CONV_CYCLES);
  // master clocks per converter clock, rounded down so throughput is not below target
  localparam int ADC_DIV = CLK_HZ / (SAMPLE_HZ * CONV_CYCLES);

  // ==========================================================
  // buffering
  localparam int FIFO_DEPTH = 32;

  // ==========================================================
  // transfer function
  localparam int XFER_MUL = 693;
  localparam int XFER_SHIFT = 10;
  localparam int XFER_OFFSET = 265;
  localparam int PROD_W = CODE_W + 10;
  localparam int DEGC_W = 11;

endpackage

// ### inc/die_temp_if.sv
// link between the temperature sensor device end and the core logic end
`timescale 1ns/1ps
interface die_temp_if;
  logic access_en;
  logic sensor_rst;
  logic code_ready;
  logic eoc;
  logic [die_temp_pkg::CODE_W-1:0] tempout;

  modport dev (
    input access_en,
    input sensor_rst,
    input code_ready,
    output eoc,
    output tempout
  );

  modport host (
    output access_en,
    output sensor_rst,
    output code_ready,
    input eoc,
    input tempout
  );
endinterface

// ### verilog/die_temp_diode_adc.sv
// sensor end: converter sequencer, result fifo and done-pulse output stage
`timescale 1ns/1ps

// ============================================================
// synchronous fifo
module die_temp_fifo #(
  parameter int WIDTH = die_temp_pkg::CODE_W,
  parameter int DEPTH = die_temp_pkg::FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign in_ready_o = !full && !clear_i;
  assign out_valid_o = !empty && !clear_i;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= '0;
    end else if (clear_i) begin
      wr_ptr_r <= '0;
    end else if (push) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ptr_r <= '0;
    end else if (clear_i) begin
      rd_ptr_r <= '0;
    end else if (pop) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

// ============================================================
// sensor device end
module die_temp_diode_adc #(
  parameter int ADC_DIV = die_temp_pkg::ADC_DIV,
  parameter int FIFO_DEPTH = die_temp_pkg::FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  die_temp_if.dev link,
  input wire logic [die_temp_pkg::CODE_W-1:0] analog_code_i,
  output logic converting_o,
  output logic code_pending_o
);
  localparam int DIV_W = (ADC_DIV > 1) ? $clog2(ADC_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ADC_DIV - 1);
  localparam logic [die_temp_pkg::CONV_CNT_W-1:0] CONV_LAST =
    die_temp_pkg::CONV_CNT_W'(die_temp_pkg::CONV_CYCLES - 1);

  typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_STORE} conv_state_t;
  typedef enum logic [1:0] {OUT_IDLE, OUT_EOC, OUT_HOLD} out_state_t;

  conv_state_t conv_state_r;
  out_state_t out_state_r;
  logic en_prev_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic adc_tick;
  logic [die_temp_pkg::CONV_CNT_W-1:0] conv_cnt_r;
  logic conv_done;
  logic [die_temp_pkg::CODE_W-1:0] result_r;
  logic [die_temp_pkg::CODE_W-1:0] tempout_r;
  logic eoc_r;
  logic start;
  logic soft_rst;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [die_temp_pkg::CODE_W-1:0] fifo_out_data;

  assign soft_rst = link.sensor_rst; // R2
  assign start = link.access_en && !en_prev_r; // R1
  assign adc_tick = (conv_state_r == CONV_RUN) && (div_cnt_r == DIV_LAST); // R7
  assign conv_done = adc_tick && (conv_cnt_r == CONV_LAST); // R3
  assign fifo_pop = fifo_out_valid && link.code_ready && (out_state_r == OUT_IDLE);

  // ==========================================================
  // access enable edge detect
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_prev_r <= 1'b0;
    end else if (soft_rst) begin
      en_prev_r <= 1'b1;
    end else begin
      en_prev_r <= link.access_en;
    end
  end

  // ==========================================================
  // conversion sequencer
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_state_r <= CONV_IDLE;
    end else if (soft_rst) begin
      conv_state_r <= CONV_IDLE; // R2
    end else begin
      case (conv_state_r)
        CONV_IDLE: begin
          if (start) begin
            conv_state_r <= CONV_RUN; // R1
          end
        end
        CONV_RUN: begin
          if (!link.access_en) begin
            conv_state_r <= CONV_IDLE;
          end else if (conv_done) begin
            conv_state_r <= CONV_STORE;
          end
        end
        CONV_STORE: begin
          if (!link.access_en) begin
            conv_state_r <= CONV_IDLE;
          end else if (fifo_in_ready) begin
            conv_state_r <= CONV_RUN; // R9
          end
        end
        default: begin
          conv_state_r <= CONV_IDLE;
        end
      endcase
    end
  end

  // converter clock enable divider
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt_r <= '0;
    end else if (soft_rst || conv_state_r != CONV_RUN || adc_tick) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  // converter clocks per conversion
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      conv_cnt_r <= '0;
    end else if (soft_rst || conv_state_r != CONV_RUN) begin
      conv_cnt_r <= '0;
    end else if (adc_tick) begin
      conv_cnt_r <= conv_cnt_r + 1'b1; // R3
    end
  end

  // result sampled at the final converter clock
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_r <= '0;
    end else if (soft_rst) begin
      result_r <= '0;
    end else if (conv_done) begin
      result_r <= analog_code_i; // R6
    end
  end

  // ==========================================================
  // result buffer
  die_temp_fifo #(
    .WIDTH(die_temp_pkg::CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) die_temp_fifo_i (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .clear_i(soft_rst),
    .in_valid_i(conv_state_r == CONV_STORE && link.access_en),
    .in_ready_o(fifo_in_ready),
    .in_data_i(result_r),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  // ==========================================================
  // done pulse output stage
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_state_r <= OUT_IDLE;
    end else if (soft_rst) begin
      out_state_r <= OUT_IDLE;
    end else begin
      case (out_state_r)
        OUT_IDLE: begin
          if (fifo_pop) begin
            out_state_r <= OUT_EOC;
          end
        end
        OUT_EOC: begin
          out_state_r <= OUT_HOLD; // R4
        end
        OUT_HOLD: begin
          out_state_r <= OUT_IDLE;
        end
        default: begin
          out_state_r <= OUT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      eoc_r <= 1'b0;
    end else if (soft_rst) begin
      eoc_r <= 1'b0;
    end else begin
      eoc_r <= fifo_pop; // R4
    end
  end

  // code changes only when a new pulse is launched or a sensor reset clears it
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tempout_r <= '0;
    end else if (soft_rst) begin
      tempout_r <= '0;
    end else if (fifo_pop) begin
      tempout_r <= fifo_out_data; // R10
    end
  end

  assign link.eoc = eoc_r;
  assign link.tempout = tempout_r;
  assign converting_o = (conv_state_r != CONV_IDLE);
  assign code_pending_o = fifo_out_valid;
endmodule

// ### verilog/die_temp_core_reader.sv
// core end: drives access enable and reset, captures codes, converts to degrees
`timescale 1ns/1ps
module die_temp_core_reader (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  die_temp_if.host link,
  input wire logic enable_i,
  input wire logic sensor_reset_i,
  input wire logic accept_i,
  output logic [die_temp_pkg::CODE_W-1:0] temp_code_o,
  output logic signed [die_temp_pkg::DEGC_W-1:0] temp_degc_o,
  output logic temp_valid_o
);
  localparam logic [die_temp_pkg::PROD_W-1:0] MUL =
    die_temp_pkg::PROD_W'(die_temp_pkg::XFER_MUL);
  localparam logic signed [die_temp_pkg::DEGC_W:0] OFFSET =
    (die_temp_pkg::DEGC_W + 1)'(die_temp_pkg::XFER_OFFSET);

  logic access_en_r;
  logic sensor_rst_r;
  logic eoc_prev_r;
  logic eoc_fall;
  logic [die_temp_pkg::PROD_W-1:0] prod;
  logic signed [die_temp_pkg::DEGC_W:0] degc;

  // ==========================================================
  // link control
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      access_en_r <= 1'b0;
    end else begin
      access_en_r <= enable_i; // R1
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sensor_rst_r <= 1'b1;
    end else begin
      sensor_rst_r <= sensor_reset_i; // R2
    end
  end

  assign link.access_en = access_en_r;
  assign link.sensor_rst = sensor_rst_r;
  assign link.code_ready = accept_i;

  // ==========================================================
  // capture on done falling edge
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      eoc_prev_r <= 1'b0;
    end else begin
      eoc_prev_r <= link.eoc;
    end
  end

  assign eoc_fall = eoc_prev_r && !link.eoc; // R5
  assign prod = die_temp_pkg::PROD_W'(link.tempout) * MUL;
  assign degc = $signed({1'b0, prod[die_temp_pkg::PROD_W-1:die_temp_pkg::XFER_SHIFT]})
    - OFFSET; // R8

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      temp_code_o <= '0;
      temp_degc_o <= '0;
    end else if (eoc_fall) begin
      temp_code_o <= link.tempout; // R5
      temp_degc_o <= degc[die_temp_pkg::DEGC_W-1:0]; // R8
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      temp_valid_o <= 1'b0;
    end else begin
      temp_valid_o <= eoc_fall;
    end
  end
endmodule

// ### tb/die_temp_asserts.sv
// link checker for the sensor end and core end
`timescale 1ns/1ps
module die_temp_asserts #(
  parameter int ADC_DIV = die_temp_pkg::ADC_DIV
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic access_en,
  input wire logic sensor_rst,
  input wire logic code_ready,
  input wire logic eoc,
  input wire logic [die_temp_pkg::CODE_W-1:0] tempout
);
  localparam int CONV_MIN = die_temp_pkg::CONV_CYCLES * ADC_DIV;
  localparam int CONV_MAX = CONV_MIN + 8;
  logic en_d_r;
  logic started_r;
  logic [19:0] run_cnt_r;
  logic [19:0] gap_cnt_r;
  logic rise;
  assign rise = access_en && !en_d_r && !sensor_rst;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // helper counters
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_d_r <= 1'b0;
      started_r <= 1'b0;
    end else begin
      // a clear arms the edge detector high, as the device does
      en_d_r <= sensor_rst ? 1'b1 : access_en;
      started_r <= !sensor_rst && (started_r || rise);
    end
  end
  // cycles since the conversion start was taken
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_cnt_r <= 20'h00000;
    end else if (sensor_rst || rise) begin
      run_cnt_r <= 20'h00000;
    end else if (run_cnt_r != 20'hfffff) begin
      run_cnt_r <= run_cnt_r + 20'h00001;
    end
  end
  // cycles since last done pulse while enabled and not stalled
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_cnt_r <= 20'h00000;
    end else if (!access_en || !code_ready || sensor_rst || eoc || rise || !started_r) begin
      gap_cnt_r <= 20'h00000;
    end else if (gap_cnt_r != 20'hfffff) begin
      gap_cnt_r <= gap_cnt_r + 20'h00001;
    end
  end
  // ==========================================================
  // properties
  property p_done_pulse;
    eoc |=> !eoc [*2];
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done pulse too long");
  property p_code_hold;
    eoc && !sensor_rst |=> $stable(tempout);
  endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("code moved after done");
  property p_clear;
    sensor_rst |=> !eoc && tempout == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear ignored");
  property p_conv_min;
    eoc && access_en |-> run_cnt_r >= CONV_MIN;
  endproperty
  a_conv_min: assert property (p_conv_min)
    else $error("conversion too short");
  property p_repeat;
    gap_cnt_r <= CONV_MAX;
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("next conversion late");
  property p_ready;
    eoc |-> $past(code_ready);
  endproperty
  a_ready: assert property (p_ready)
    else $error("done without ready");
  property p_start;
    eoc |-> started_r;
  endproperty
  a_start: assert property (p_start)
    else $error("done without start");
  property p_release;
    sensor_rst ##1 !sensor_rst |-> !eoc [*3];
  endproperty
  a_release: assert property (p_release)
    else $error("done right after clear");
endmodule

// ### tb/die_temperature_adc_readout_test.sv
// self-checking bench joining the sensor end and the core end
`timescale 1ns/1ps
module die_temperature_adc_readout_test;
  localparam int DIV = 4;
  localparam int DEPTH = 4;
  localparam int CONV = 1024 * DIV;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic enable_i = 1'b0;
  logic sensor_reset_i = 1'b1;
  logic accept_i = 1'b1;
  logic [9:0] analog_code_i = 10'h000;
  logic [9:0] temp_code_o;
  logic signed [10:0] temp_degc_o;
  logic temp_valid_o;
  logic converting_o;
  logic code_pending_o;
  logic [15:0] lfsr_r = 16'h0982;
  logic [9:0] v;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  int cnt;
  die_temp_if die_temp_if_i ();
  die_temp_diode_adc #(.ADC_DIV(DIV), .FIFO_DEPTH(DEPTH)) die_temp_diode_adc_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(die_temp_if_i.dev),
    .analog_code_i(analog_code_i), .converting_o(converting_o),
    .code_pending_o(code_pending_o));
  die_temp_core_reader die_temp_core_reader_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(die_temp_if_i.host),
    .enable_i(enable_i), .sensor_reset_i(sensor_reset_i), .accept_i(accept_i),
    .temp_code_o(temp_code_o), .temp_degc_o(temp_degc_o), .temp_valid_o(temp_valid_o));
  die_temp_asserts #(.ADC_DIV(DIV)) die_temp_asserts_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .access_en(die_temp_if_i.access_en),
    .sensor_rst(die_temp_if_i.sensor_rst), .code_ready(die_temp_if_i.code_ready),
    .eoc(die_temp_if_i.eoc), .tempout(die_temp_if_i.tempout));
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end
  // ==========================================================
  // expectations and comparisons
  function automatic logic signed [10:0] degc_of(input logic [9:0] c);
    return 11'(((int'(c) * 693) >> 10) - 265);
  endfunction
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check_val(input string what, input logic [10:0] exp, input logic [10:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  // ==========================================================
  // drivers
  task automatic wait_valid(input int limit, output int k);
    k = 0;
    @(negedge mclk_i);
    while (temp_valid_o !== 1'b1 && k < limit) begin
      @(negedge mclk_i);
      k++;
    end
  endtask
  task automatic read_check(input logic [9:0] c);
    @(posedge mclk_i);
    analog_code_i <= c;
    enable_i <= 1'b0;
    sensor_reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sensor_reset_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    enable_i <= 1'b1;
    wait_valid(CONV + 20, n);
    check_flag("latency", 1'b1, n >= CONV + 4 && n <= CONV + 8);
    check_val("code", {1'b0, c}, {1'b0, temp_code_o});
    check_val("degrees", degc_of(c), temp_degc_o);
    check_flag("converting", 1'b1, converting_o);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : lfsr_r[9:0];
      lfsr_r = lfsr_next(lfsr_r);
      read_check(v);
    end
    @(posedge mclk_i);
    analog_code_i <= lfsr_r[9:0];
    wait_valid(CONV + 20, n);
    check_flag("repeat gap", 1'b1, n <= CONV + 8);
    check_val("repeat code", {1'b0, lfsr_r[9:0]}, {1'b0, temp_code_o});
    @(posedge mclk_i);
    accept_i <= 1'b0;
    analog_code_i <= 10'h2a5;
    wait_valid(CONV * (DEPTH + 2), n);
    check_flag("stalled valid", 1'b0, temp_valid_o);
    check_flag("pending", 1'b1, code_pending_o);
    @(posedge mclk_i);
    accept_i <= 1'b1;
    cnt = 0;
    repeat (40) begin
      @(negedge mclk_i);
      if (temp_valid_o === 1'b1) begin
        cnt++;
        check_val("buffered code", 11'h2a5, {1'b0, temp_code_o});
      end
    end
    check_flag("buffered count", 1'b1, cnt >= DEPTH && cnt <= DEPTH + 1);
    check_flag("drained", 1'b0, code_pending_o);
    repeat (CONV / 2) @(posedge mclk_i);
    sensor_reset_i <= 1'b1;
    enable_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    sensor_reset_i <= 1'b0;
    @(negedge mclk_i);
    check_val("link code", 11'h000, {1'b0, die_temp_if_i.tempout});
    wait_valid(CONV + 20, n);
    check_flag("valid after clear", 1'b0, temp_valid_o);
    check_flag("idle after clear", 1'b0, converting_o);
    read_check(lfsr_r[15:6]);
    n = die_temp_pkg::CLK_HZ / (die_temp_pkg::CONV_CYCLES * die_temp_pkg::ADC_DIV);
    check_flag("sample rate", 1'b1, n >= 990 && n <= 1010);
    finish_test();
  end
endmodule
